// *** dsp_interrupt_clock_pins.v ***
// Pin-level interrupt arbitration, acknowledge, and clock outputs
`timescale 1ns/1ns
`include "irq_clk_regs.vh"
module dsp_interrupt_clock_pins
(
    // Clock and reset
    input  wire                      clk,
    input  wire                      sys_rst,
    // External interrupt pins
    input  wire                      ext_irq_pin_a,
    input  wire                      ext_irq_pin_b,
    input  wire                      ext_irq_pin_c,
    input  wire                      ext_irq_pin_d,
    input  wire                      nmi_pin,
    input  wire [`NUM_EXT_IRQ-1:0]   ext_irq_polarity_bits,
    // Internal interrupt sources at positions 8..15, bits 0..7 unused
    input  wire [`NUM_CORE_IRQ-1:0]  int_irq_src,
    input  wire [`NUM_CORE_IRQ-1:0]  irq_enable,
    // Core service handshake
    input  wire                      core_ready,
    // Clock-mode straps
    input  wire                      pll_factor_select_0,
    input  wire                      pll_factor_select_1,
    input  wire                      pll_factor_select_2,
    // Outputs
    output reg                       irq_service_ack_out,
    output reg                       irq_number_out_b3,
    output reg                       irq_number_out_b2,
    output reg                       irq_number_out_b1,
    output reg                       irq_number_out_b0,
    output reg  [`NUM_CORE_IRQ-1:0]  irq_pending,
    output reg                       core_rate_clock_out,
    output reg                       half_rate_clock_out,
    output reg  [`FACTOR_SEL_W-1:0]  pll_factor_sel
);
    localparam ST_IDLE = 2'b01;
    localparam ST_SERV = 2'b10;

    wire [`NUM_EXT_IRQ-1:0] ext_pins;
    wire [`NUM_EXT_IRQ-1:0] ext_evt;
    wire                    nmi_evt;
    reg  [1:0]              state_q;
    reg  [`NUM_CORE_IRQ-1:0] pend_d;
    reg  [`NUM_CORE_IRQ-1:0] set_vec;
    reg  [`NUM_CORE_IRQ-1:0] clr_vec;
    reg                     core_div_q;
    reg                     half_div_q;
    reg                     strap_taken_q;
    reg  [`FACTOR_SEL_W-1:0] sel_meta_q;
    reg  [`FACTOR_SEL_W-1:0] sel_sync_q;
    reg  [`FACTOR_SEL_W-1:0] sel_prev_q;
    reg  [2:0]              fill_q;

    assign ext_pins = {ext_irq_pin_d, ext_irq_pin_c, ext_irq_pin_b, ext_irq_pin_a};

    genvar gi;
    generate
        for (gi = 0; gi < `NUM_EXT_IRQ; gi = gi + 1)
        begin : g_ext
            edge_sync u_sync
            (
                .clk       (clk),
                .sys_rst   (sys_rst),
                .pin_in    (ext_pins[gi]),
                .rise_sel  (ext_irq_polarity_bits[gi]),
                .event_out (ext_evt[gi])
            );
        end
    endgenerate

    edge_sync u_nmi
    (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .pin_in    (nmi_pin),
        .rise_sel  (1'b1),
        .event_out (nmi_evt)
    );

    // Lowest set index wins; bit 0 (reset) is never pended here
    function [`IRQ_NUM_W:0] pick;
        input [`NUM_CORE_IRQ-1:0] req;
        integer k;
        begin
            pick = {1'b0, {`IRQ_NUM_W{1'b0}}};
            for (k = `NUM_CORE_IRQ - 1; k >= 0; k = k - 1)
                if (req[k])
                    pick = {1'b1, k[`IRQ_NUM_W-1:0]};
        end
    endfunction

    wire [`IRQ_NUM_W:0] winner;
    assign winner = pick(irq_pending & irq_enable);

    // Grant decode shared by the pending clear and the acknowledge
    function grant_ok;
        input [1:0]          st;
        input                rdy;
        input [`IRQ_NUM_W:0] win;
        begin
            grant_ok = (st == ST_IDLE) && rdy && win[`IRQ_NUM_W];
        end
    endfunction

    always @*
    begin
        set_vec = int_irq_src;
        set_vec[`IRQ_EXT_BASE +: `NUM_EXT_IRQ] = ext_evt;
        set_vec[`IRQ_NMI] = nmi_evt;
        set_vec[0] = 1'b0;
        set_vec[2] = 1'b0;
        set_vec[3] = 1'b0;
        clr_vec = {`NUM_CORE_IRQ{1'b0}};
        if (grant_ok(state_q, core_ready, winner))
            clr_vec[winner[`IRQ_NUM_W-1:0]] = 1'b1;
        // A new event in the clear cycle stays pending
        pend_d = (irq_pending & ~clr_vec) | set_vec;
    end

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_q             <= ST_IDLE;
            irq_pending         <= {`NUM_CORE_IRQ{1'b0}};
            irq_service_ack_out <= 1'b0;
            irq_number_out_b3   <= 1'b0;
            irq_number_out_b2   <= 1'b0;
            irq_number_out_b1   <= 1'b0;
            irq_number_out_b0   <= 1'b0;
        end
        else
        begin
            irq_pending         <= pend_d;
            irq_service_ack_out <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    if (grant_ok(state_q, core_ready, winner))
                    begin
                        irq_service_ack_out <= 1'b1;
                        irq_number_out_b3   <= winner[3];
                        irq_number_out_b2   <= winner[2];
                        irq_number_out_b1   <= winner[1];
                        irq_number_out_b0   <= winner[0];
                        state_q             <= ST_SERV;
                    end
                end
                // One dead cycle keeps acks from running back to back
                ST_SERV:
                    state_q <= ST_IDLE;
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // Clock outputs are registered, so full rate here means one toggle per edge
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            core_div_q          <= 1'b0;
            half_div_q          <= 1'b0;
            core_rate_clock_out <= 1'b0;
            half_rate_clock_out <= 1'b0;
        end
        else
        begin
            core_div_q          <= ~core_div_q;
            core_rate_clock_out <= ~core_div_q;
            if (core_div_q)
                half_div_q <= ~half_div_q;
            half_rate_clock_out <= half_div_q;
        end
    end

    // Straps are static; sampled once after reset release and then held
    // Only the second and third stages are read, so the first stage can settle
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            sel_meta_q <= {`FACTOR_SEL_W{1'b0}};
            sel_sync_q <= {`FACTOR_SEL_W{1'b0}};
            sel_prev_q <= {`FACTOR_SEL_W{1'b0}};
            fill_q     <= 3'h0;
        end
        else
        begin
            sel_meta_q <= {pll_factor_select_2, pll_factor_select_1, pll_factor_select_0};
            sel_sync_q <= sel_meta_q;
            sel_prev_q <= sel_sync_q;
            fill_q     <= {fill_q[1:0], 1'b1};
        end
    end

    // Capture waits for a filled pipeline so reset zeros are never taken as straps
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            strap_taken_q  <= 1'b0;
            pll_factor_sel <= {`FACTOR_SEL_W{1'b0}};
        end
        else if (!strap_taken_q && fill_q[2] && sel_sync_q == sel_prev_q)
        begin
            pll_factor_sel <= sel_sync_q;
            strap_taken_q  <= 1'b1;
        end
    end
endmodule

// *** irq_clk_regs.vh ***
// Constants for the interrupt and clock-output pin block
`ifndef IRQ_CLK_REGS_VH
`define IRQ_CLK_REGS_VH
`define NUM_EXT_IRQ      4
`define NUM_CORE_IRQ     16
`define IRQ_NUM_W        4
`define IRQ_NMI          4'h1
`define IRQ_EXT_BASE     4
`define FACTOR_SEL_W     3
`define SERVICE_CYCLES   2
`endif

// *** edge_sync.v ***
// Two-flop synchroniser with selectable-edge single-cycle event output
`timescale 1ns/1ns
module edge_sync
(
    // Clock and reset
    input  wire clk,
    input  wire sys_rst,
    // Pin and polarity
    input  wire pin_in,
    input  wire rise_sel,
    // Event
    output reg  event_out
);
    reg meta_q;
    reg sync_q;
    reg last_q;

    // Only sync_q and last_q are read beyond the first stage
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            meta_q    <= 1'b0;
            sync_q    <= 1'b0;
            last_q    <= 1'b0;
            event_out <= 1'b0;
        end
        else
        begin
            meta_q    <= pin_in;
            sync_q    <= meta_q;
            last_q    <= sync_q;
            event_out <= rise_sel ? (sync_q & ~last_q) : (~sync_q & last_q);
        end
    end
endmodule

// *** irq_pins_chk_asserts.sv ***
// Checker for the interrupt and clock-output pin block
`timescale 1ns/1ns
module irq_pins_chk
(
    // Clock, reset and inputs
    input wire        clk,
    input wire        sys_rst,
    input wire        ext_irq_pin_a,
    input wire        nmi_pin,
    input wire        core_ready,
    input wire [3:0]  ext_irq_polarity_bits,
    input wire [15:0] irq_enable,
    input wire        pll_factor_select_0,
    input wire        pll_factor_select_1,
    input wire        pll_factor_select_2,
    // Outputs
    input wire        irq_service_ack_out,
    input wire        irq_number_out_b3,
    input wire        irq_number_out_b2,
    input wire        irq_number_out_b1,
    input wire        irq_number_out_b0,
    input wire [15:0] irq_pending,
    input wire        core_rate_clock_out,
    input wire        half_rate_clock_out,
    input wire [2:0]  pll_factor_sel
);
    wire [3:0]  num = {irq_number_out_b3, irq_number_out_b2, irq_number_out_b1, irq_number_out_b0};
    wire [15:0] pe = irq_pending & irq_enable;
    reg  [1:0]  run_q;
    // Clock outputs are only judged once they have left their reset phase
    always @(posedge clk) run_q <= sys_rst ? 2'h0 : (run_q == 2'h3 ? run_q : run_q + 2'h1);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence half_step_s;
        $stable(half_rate_clock_out) ##1 $changed(half_rate_clock_out);
    endsequence
    ack_single_a: assert property (irq_service_ack_out |=> !irq_service_ack_out)
        else $error("ack wider than one cycle");
    ack_cause_a: assert property (irq_service_ack_out |-> $past(core_ready && pe != 16'h0000))
        else $error("ack without enabled pending request");
    ack_number_a: assert property (irq_service_ack_out |->
        ($past(pe) & ((16'h0002 << num) - 16'h0001)) == (16'h0001 << num)) else $error("bad number");
    core_clk_a: assert property (run_q == 2'h3 |-> $changed(core_rate_clock_out))
        else $error("core rate clock stalled");
    half_clk_a: assert property (run_q == 2'h3 && $changed(half_rate_clock_out) |=> half_step_s)
        else $error("half rate clock wrong");
    strap_hold_a: assert property (pll_factor_sel != 3'h0 |->
        pll_factor_sel == {pll_factor_select_2, pll_factor_select_1, pll_factor_select_0})
        else $error("strap capture wrong");
    ext_edge_a: assert property (($rose(ext_irq_pin_a) && ext_irq_polarity_bits[0]) ||
        ($fell(ext_irq_pin_a) && !ext_irq_polarity_bits[0]) |-> ##[1:6] irq_pending[4])
        else $error("edge on pin a lost");
    nmi_edge_a: assert property ($rose(nmi_pin) |-> ##[1:6] irq_pending[1])
        else $error("nmi edge lost");
endmodule

// *** irq_pin_source.sv ***
// Board-side interrupt sources driving the pins
`timescale 1ns/1ns
module irq_pin_source
(
    input  wire       clk,
    input  wire [4:0] fire,
    output reg  [4:0] pins
);
    // Each request toggles a line, so its edge alternates between rise and fall
    initial pins = 5'h00;
    always @(posedge clk) pins <= pins ^ fire;
endmodule

// *** tb_dsp_interrupt_clock_pins.sv ***
// Random and corner tests of the interrupt and clock-output pin block
`timescale 1ns/1ns
module tb_dsp_interrupt_clock_pins;
    reg         clk = 0, sys_rst = 1, rdy = 0;
    reg  [3:0]  pol = 4'h0;
    reg  [15:0] src = 16'h0000, en = 16'hffff, exp;
    reg  [4:0]  fire = 5'h00;
    reg  [2:0]  strap = 3'h0;
    wire [4:0]  pins;
    wire        ack, n3, n2, n1, n0, c1, c2;
    wire [15:0] pend;
    wire [2:0]  fsel;
    integer     n_errors = 0, comparisons = 0, cyc = 0, r, i, s;
    irq_pin_source u_irq_pin_source (.clk(clk), .fire(fire), .pins(pins));
    dsp_interrupt_clock_pins u_dsp_interrupt_clock_pins (.clk(clk), .sys_rst(sys_rst),
        .ext_irq_pin_a(pins[0]), .ext_irq_pin_b(pins[1]), .ext_irq_pin_c(pins[2]),
        .ext_irq_pin_d(pins[3]), .nmi_pin(pins[4]), .ext_irq_polarity_bits(pol),
        .int_irq_src(src), .irq_enable(en), .core_ready(rdy), .pll_factor_select_0(strap[0]),
        .pll_factor_select_1(strap[1]), .pll_factor_select_2(strap[2]),
        .irq_service_ack_out(ack), .irq_number_out_b3(n3), .irq_number_out_b2(n2),
        .irq_number_out_b1(n1), .irq_number_out_b0(n0), .irq_pending(pend),
        .core_rate_clock_out(c1), .half_rate_clock_out(c2), .pll_factor_sel(fsel));
    initial forever #25 clk = ~clk;
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            n_errors = n_errors + 1;
            conclude;
        end
    end
    task conclude;
    begin
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    end
    endtask
    task check(input [8*7-1:0] what, input [16:0] e, input [16:0] g);
    begin
        comparisons = comparisons + 1;
        if (g !== e)
        begin
            n_errors = n_errors + 1;
            $display("mismatch %0s expected %h seen %h", what, e, g);
        end
    end
    endtask
    task tick;
    begin
        @(posedge clk);
        #1;
    end
    endtask
    // Waits a bounded time for the acknowledge, then checks it with the number
    task take(input [3:0] e);
        integer k;
    begin
        k = 0;
        tick;
        while (ack !== 1'b1 && k < 8)
        begin
            tick;
            k = k + 1;
        end
        check("ack_num", {13'h1, e}, {13'h0, ack, n3, n2, n1, n0});
    end
    endtask
    // A toggle qualifies when the line moves towards the selected level
    function [15:0] want(input [4:0] f, input [4:0] p, input [3:0] pl);
        integer k;
    begin
        want = 16'h0000;
        for (k = 0; k < 4; k = k + 1) want[4 + k] = f[k] && (pl[k] != p[k]);
        want[1] = f[4] && !p[4];
    end
    endfunction
    initial
    begin
        r = $urandom(74427);
        strap = 3'h4 | $urandom;
        repeat (2) @(posedge clk);
        #1 sys_rst = 0;
        repeat (6) tick;
        check("strap", strap, fsel);
        for (i = 0; i < 4; i = i + 1)
        begin
            exp[1:0] = {c2, c1};
            tick;
            check("clk1", !exp[0], c1);
            tick;
            check("clk2", !exp[1], c2);
        end
        for (r = 0; r < 40; r = r + 1)
        begin
            rdy = 0;
            pol = $urandom;
            fire = $urandom;
            if (r == 0) fire = 5'h1f;
            if (r == 0) pol = ~pins[3:0];
            s = 8 + $urandom % 8;
            en = 16'hffff;
            en[s] = 1'b0;
            exp = want(fire, pins, pol);
            src[s] = 1'b1;
            tick;
            src = 16'h0000;
            fire = 5'h00;
            repeat (8) tick;
            check("pending", exp | (16'h0001 << s), pend);
            rdy = 1;
            for (i = 0; i < 8; i = i + 1) if (exp[i]) take(i);
            repeat (4) tick;
            check("masked", 16'h0001 << s, pend);
            en = 16'hffff;
            take(s);
        end
        conclude;
    end
endmodule
bind dsp_interrupt_clock_pins irq_pins_chk u_irq_pins_chk (.clk, .sys_rst, .ext_irq_pin_a,
    .nmi_pin, .core_ready, .ext_irq_polarity_bits, .irq_enable, .pll_factor_select_0,
    .pll_factor_select_1, .pll_factor_select_2, .irq_service_ack_out, .irq_number_out_b3,
    .irq_number_out_b2, .irq_number_out_b1, .irq_number_out_b0, .irq_pending,
    .core_rate_clock_out, .half_rate_clock_out, .pll_factor_sel);
